// ==== src/rcf_pkg.sv ====
// Package for the reset cause flag block: register map, field positions and reset values.
package rcf_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [3:0] RCF_ADDR_STATUS = 4'h0;
  localparam logic [3:0] RCF_ADDR_CTRL = 4'h4;
  localparam logic [3:0] RCF_ADDR_INT_STAT = 4'h8;
  localparam logic [3:0] RCF_ADDR_INT_MASK = 4'hc;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int RCF_BIT_SOFTWARE = 5;
  localparam int RCF_BIT_INDEP_WDOG = 6;
  localparam int RCF_BIT_WINDOW_WDOG = 7;
  localparam int RCF_BIT_LOW_POWER = 8;
  localparam int RCF_BIT_CLOCK_FAIL = 9;
  localparam int RCF_FLAG_LO = 5;
  localparam int RCF_FLAG_HI = 9;
  localparam int RCF_NUM_FLAGS = 5;
  localparam int RCF_BIT_REMOVE = 0;
  localparam int RCF_BYTE_BITS = 8;

  // ==========================================================================
  // Reset values and bus answers
  // ==========================================================================
  localparam logic [4:0] RCF_FLAGS_RST = 5'h00;
  localparam logic [31:0] RCF_WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] RCF_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCF_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RCF_WR_IDLE = 2'h1,
    RCF_WR_RESP = 2'h2
  } rcf_wr_state_type;

endpackage

// ==== src/rcf_reset_cause_flags.sv ====
// Reset cause flag register with AXI4-Lite slave and interrupt.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

// ============================================================================
// Reset cause flags
// ============================================================================
// Operation
// - Clock-failure detector reset sets flag bit 9.
// - Low-power entry reset sets flag bit 8.
// - Window watchdog reset sets flag bit 7.
// - Independent watchdog reset sets flag bit 6.
// - Software system reset sets flag bit 5.
// - Flags clear only by the remove-flags write or power-on reset.
// - A flag reads one after its source fired since clear, else zero.
module rcf_reset_cause_flags (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic POR_RESET_N,
  input wire logic CLOCK_FAIL_DETECTOR_RESET,
  input wire logic LOW_POWER_RESET,
  input wire logic WINDOW_WATCHDOG_RESET,
  input wire logic INDEPENDENT_WATCHDOG_RESET,
  input wire logic SOFTWARE_RESET,
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic IRQ
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] src_events;
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] flags_q;
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] flags_d;
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] int_stat_q;
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] int_stat_d;
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] int_mask_q;
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] int_mask_d;
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] lane_en;
  logic [rcf_pkg::RCF_NUM_FLAGS-1:0] stat_clr;
  logic [3:0] awaddr_q;
  logic aw_have_q;
  logic [31:0] wdata_q;
  logic w_have_q;
  logic [3:0] wstrb_q;
  rcf_pkg::rcf_wr_state_type wr_state_q;
  logic sys_reset_n;
  logic wr_idle;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic wr_addr_ok;
  logic remove_strobe;
  logic stat_write;
  logic mask_write;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_word;
  logic rd_addr_ok;
  logic irq_q;

  // ==========================================================================
  // Reset domains
  // ==========================================================================
  // Bus and interrupt state fall back on either reset; the cause flags listen
  // to the power-on reset only, so a system reset leaves its own trace behind.
  assign sys_reset_n = RESET_N & POR_RESET_N;

  // ==========================================================================
  // Reset source events
  // ==========================================================================
  // Sources are levels; a source held high simply keeps its flag set.
  assign src_events[rcf_pkg::RCF_BIT_CLOCK_FAIL - rcf_pkg::RCF_FLAG_LO] = CLOCK_FAIL_DETECTOR_RESET;
  assign src_events[rcf_pkg::RCF_BIT_LOW_POWER - rcf_pkg::RCF_FLAG_LO] = LOW_POWER_RESET;
  assign src_events[rcf_pkg::RCF_BIT_WINDOW_WDOG - rcf_pkg::RCF_FLAG_LO] = WINDOW_WATCHDOG_RESET;
  assign src_events[rcf_pkg::RCF_BIT_INDEP_WDOG - rcf_pkg::RCF_FLAG_LO] = INDEPENDENT_WATCHDOG_RESET;
  assign src_events[rcf_pkg::RCF_BIT_SOFTWARE - rcf_pkg::RCF_FLAG_LO] = SOFTWARE_RESET;

  // ==========================================================================
  // Write address and data channels
  // ==========================================================================
  // Address and data are taken in either order and parked until both are
  // present; nothing new is taken while a response is still pending.
  assign wr_idle = (wr_state_q == rcf_pkg::RCF_WR_IDLE);
  assign AWREADY = wr_idle && !aw_have_q;
  assign WREADY = wr_idle && !w_have_q;
  assign aw_take = AWVALID && AWREADY;
  assign w_take = WVALID && WREADY;
  assign wr_fire = sys_reset_n && wr_idle && aw_have_q && w_have_q;

  always_ff @(posedge CLK) begin
    if (!sys_reset_n) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 4'h0;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      awaddr_q <= AWADDR;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!sys_reset_n) begin
      w_have_q <= 1'b0;
      wdata_q <= rcf_pkg::RCF_WORD_ZERO;
      wstrb_q <= 4'h0;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Write sequencing
  // ==========================================================================
  // The write takes effect in the cycle it fires; the response then waits.
  always_ff @(posedge CLK) begin
    if (!sys_reset_n) begin
      wr_state_q <= rcf_pkg::RCF_WR_IDLE;
    end else begin
      case (wr_state_q)
        rcf_pkg::RCF_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_q <= rcf_pkg::RCF_WR_RESP;
          end
        end
        rcf_pkg::RCF_WR_RESP: begin
          if (BREADY) begin
            wr_state_q <= rcf_pkg::RCF_WR_IDLE;
          end
        end
        default: begin
          wr_state_q <= rcf_pkg::RCF_WR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Write decode
  // ==========================================================================
  // The status word ignores writes; an unknown address answers with an error.
  always_comb begin
    wr_addr_ok = 1'b1;
    remove_strobe = 1'b0;
    stat_write = 1'b0;
    mask_write = 1'b0;
    if (awaddr_q == rcf_pkg::RCF_ADDR_STATUS) begin
      wr_addr_ok = 1'b1;
    end else if (awaddr_q == rcf_pkg::RCF_ADDR_CTRL) begin
      remove_strobe = wr_fire && wstrb_q[rcf_pkg::RCF_BIT_REMOVE / rcf_pkg::RCF_BYTE_BITS]
        && wdata_q[rcf_pkg::RCF_BIT_REMOVE];
    end else if (awaddr_q == rcf_pkg::RCF_ADDR_INT_STAT) begin
      stat_write = wr_fire;
    end else if (awaddr_q == rcf_pkg::RCF_ADDR_INT_MASK) begin
      mask_write = wr_fire;
    end else begin
      wr_addr_ok = 1'b0;
    end
  end

  // ==========================================================================
  // Write response
  // ==========================================================================
  always_ff @(posedge CLK) begin
    if (!sys_reset_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= rcf_pkg::RCF_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_addr_ok ? rcf_pkg::RCF_RESP_OKAY : rcf_pkg::RCF_RESP_SLVERR;
    end else if (bvalid_q && BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  // ==========================================================================
  // Read channel
  // ==========================================================================
  // One read at a time: the address is refused while read data still stands.
  assign ARREADY = !rvalid_q;
  assign ar_take = ARVALID && ARREADY;

  always_comb begin
    rd_word = rcf_pkg::RCF_WORD_ZERO;
    rd_addr_ok = 1'b1;
    if (ARADDR == rcf_pkg::RCF_ADDR_STATUS) begin
      rd_word[rcf_pkg::RCF_FLAG_HI:rcf_pkg::RCF_FLAG_LO] = flags_q;
    end else if (ARADDR == rcf_pkg::RCF_ADDR_CTRL) begin
      rd_word = rcf_pkg::RCF_WORD_ZERO;
    end else if (ARADDR == rcf_pkg::RCF_ADDR_INT_STAT) begin
      rd_word[rcf_pkg::RCF_FLAG_HI:rcf_pkg::RCF_FLAG_LO] = int_stat_q;
    end else if (ARADDR == rcf_pkg::RCF_ADDR_INT_MASK) begin
      rd_word[rcf_pkg::RCF_FLAG_HI:rcf_pkg::RCF_FLAG_LO] = int_mask_q;
    end else begin
      rd_addr_ok = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!sys_reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= rcf_pkg::RCF_WORD_ZERO;
      rresp_q <= rcf_pkg::RCF_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_addr_ok ? rcf_pkg::RCF_RESP_OKAY : rcf_pkg::RCF_RESP_SLVERR;
    end else if (rvalid_q && RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  // ==========================================================================
  // Flag, interrupt status and mask bits
  // ==========================================================================
  // A source event wins over a clear that lands in the same cycle, so no
  // reset cause can slip through unrecorded.
  for (genvar i = 0; i < rcf_pkg::RCF_NUM_FLAGS; i++) begin : g_flag_bit
    localparam int FIELD = rcf_pkg::RCF_FLAG_LO + i;
    assign lane_en[i] = wstrb_q[FIELD / rcf_pkg::RCF_BYTE_BITS];
    assign flags_d[i] = src_events[i] | (flags_q[i] & ~remove_strobe);
    assign stat_clr[i] = stat_write & lane_en[i] & wdata_q[FIELD];
    assign int_stat_d[i] = src_events[i] | (int_stat_q[i] & ~stat_clr[i]);
    assign int_mask_d[i] = (mask_write & lane_en[i]) ? wdata_q[FIELD] : int_mask_q[i];
  end

  always_ff @(posedge CLK) begin
    if (!POR_RESET_N) begin
      flags_q <= rcf_pkg::RCF_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!sys_reset_n) begin
      int_stat_q <= rcf_pkg::RCF_FLAGS_RST;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!sys_reset_n) begin
      int_mask_q <= ~rcf_pkg::RCF_FLAGS_RST;
    end else begin
      int_mask_q <= int_mask_d;
    end
  end

  // ==========================================================================
  // Interrupt output
  // ==========================================================================
  // All sources come out of reset masked; a mask bit of one blocks its status.
  always_ff @(posedge CLK) begin
    if (!sys_reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(int_stat_q & ~int_mask_q);
    end
  end

  assign IRQ = irq_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_clock_fail_sets;
    @(posedge CLK) disable iff (!POR_RESET_N)
      CLOCK_FAIL_DETECTOR_RESET |=> flags_q[rcf_pkg::RCF_BIT_CLOCK_FAIL - rcf_pkg::RCF_FLAG_LO];
  endproperty
  a_clock_fail_sets: assert property (p_clock_fail_sets)
    else $error("clock fail flag not set after its reset");

  property p_low_power_sets;
    @(posedge CLK) disable iff (!POR_RESET_N)
      LOW_POWER_RESET |=> flags_q[rcf_pkg::RCF_BIT_LOW_POWER - rcf_pkg::RCF_FLAG_LO];
  endproperty
  a_low_power_sets: assert property (p_low_power_sets)
    else $error("low power flag not set after its reset");

  property p_window_wdog_sets;
    @(posedge CLK) disable iff (!POR_RESET_N)
      WINDOW_WATCHDOG_RESET |=> flags_q[rcf_pkg::RCF_BIT_WINDOW_WDOG - rcf_pkg::RCF_FLAG_LO];
  endproperty
  a_window_wdog_sets: assert property (p_window_wdog_sets)
    else $error("window watchdog flag not set after its reset");

  property p_indep_wdog_sets;
    @(posedge CLK) disable iff (!POR_RESET_N)
      INDEPENDENT_WATCHDOG_RESET |=> flags_q[rcf_pkg::RCF_BIT_INDEP_WDOG - rcf_pkg::RCF_FLAG_LO];
  endproperty
  a_indep_wdog_sets: assert property (p_indep_wdog_sets)
    else $error("independent watchdog flag not set after its reset");

  property p_software_sets;
    @(posedge CLK) disable iff (!POR_RESET_N)
      SOFTWARE_RESET |=> flags_q[rcf_pkg::RCF_BIT_SOFTWARE - rcf_pkg::RCF_FLAG_LO];
  endproperty
  a_software_sets: assert property (p_software_sets)
    else $error("software flag not set after its reset");

  property p_flags_clear_only_by_remove;
    @(posedge CLK) disable iff (!POR_RESET_N)
      !remove_strobe |=> ((flags_q & $past(flags_q)) == $past(flags_q));
  endproperty
  a_flags_clear_only_by_remove: assert property (p_flags_clear_only_by_remove)
    else $error("flag cleared without a remove request");

  property p_status_read;
    @(posedge CLK) disable iff (!sys_reset_n)
      (ar_take && (ARADDR == rcf_pkg::RCF_ADDR_STATUS)) |=>
        (RDATA[rcf_pkg::RCF_FLAG_HI:rcf_pkg::RCF_FLAG_LO] == $past(flags_q));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not show the flags");

  property p_flags_survive_reset;
    @(posedge CLK) disable iff (!POR_RESET_N)
      !RESET_N |=> (flags_q == ($past(flags_q) | $past(src_events)));
  endproperty
  a_flags_survive_reset: assert property (p_flags_survive_reset)
    else $error("flags disturbed by system reset");
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the reset cause flag block.
`timescale 1ns/1ps
module tb_top;
  logic CLK = 0, RESET_N = 0, POR_RESET_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [1:0] BRESP, RRESP;
  logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hf;
  logic [4:0] src = 5'h00;
  logic [31:0] WDATA = 32'h0, RDATA, v;
  logic [1:0] r;
  int miscompares = 0, n_checks = 0;
  localparam logic [36:0] rows [5] = '{{5'h01, 32'h20}, {5'h02, 32'h40}, {5'h04, 32'h80}, {5'h08, 32'h100},
    {5'h10, 32'h200}};
  always #25 CLK = ~CLK;
  rcf_reset_cause_flags DUT (.CLK(CLK), .RESET_N(RESET_N), .POR_RESET_N(POR_RESET_N),
    .CLOCK_FAIL_DETECTOR_RESET(src[4]), .LOW_POWER_RESET(src[3]), .WINDOW_WATCHDOG_RESET(src[2]),
    .INDEPENDENT_WATCHDOG_RESET(src[1]), .SOFTWARE_RESET(src[0]), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ));
  task chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_irq(input logic e);
    chk("irq", {31'h0, e}, {31'h0, IRQ});
  endtask
  task bus(input bit w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    {AWVALID, WVALID, ARVALID, BREADY, RREADY} <= {w, w, !w, 2'b11};
    {AWADDR, ARADDR, WDATA} <= {a, a, d};
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (ARREADY) ARVALID <= 1'b0;
    end while (!(w ? BVALID : RVALID));
    v = RDATA;
    r = w ? BRESP : RRESP;
    {BREADY, RREADY} <= 2'b00;
  endtask
  task results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    {RESET_N, POR_RESET_N} <= 2'b11;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, rcf_pkg::RCF_ADDR_STATUS, 32'h0);
      chk("flags", 32'h0, v);
      src <= rows[i][36:32];
      bus(1'b0, rcf_pkg::RCF_ADDR_STATUS, 32'h0);
      src <= 5'h00;
      bus(1'b0, rcf_pkg::RCF_ADDR_STATUS, 32'h0);
      chk("flags", rows[i][31:0], v);
      bus(1'b1, rcf_pkg::RCF_ADDR_CTRL, 32'h1);
      chk("bresp", {30'h0, rcf_pkg::RCF_RESP_OKAY}, {30'h0, r});
    end
    src <= 5'h11;
    @(posedge CLK);
    {src, RESET_N} <= 6'h00;
    @(posedge CLK);
    RESET_N <= 1'b1;
    bus(1'b0, rcf_pkg::RCF_ADDR_STATUS, 32'h0);
    chk("flags", 32'h220, v);
    bus(1'b1, rcf_pkg::RCF_ADDR_INT_MASK, 32'h0);
    src <= 5'h04;
    bus(1'b0, rcf_pkg::RCF_ADDR_INT_STAT, 32'h0);
    src <= 5'h00;
    chk("int_stat", 32'h80, v);
    chk_irq(1'b1);
    bus(1'b1, rcf_pkg::RCF_ADDR_INT_STAT, 32'h80);
    bus(1'b0, rcf_pkg::RCF_ADDR_INT_STAT, 32'h0);
    chk("int_stat", 32'h0, v);
    chk_irq(1'b0);
    bus(1'b1, rcf_pkg::RCF_ADDR_INT_MASK, 32'h80);
    src <= 5'h04;
    bus(1'b0, rcf_pkg::RCF_ADDR_INT_STAT, 32'h0);
    src <= 5'h00;
    chk("int_stat", 32'h80, v);
    chk_irq(1'b0);
    bus(1'b0, rcf_pkg::RCF_ADDR_STATUS, 32'h0);
    chk("flags", 32'h2a0, v);
    bus(1'b0, 4'h2, 32'h0);
    chk("rresp", {30'h0, rcf_pkg::RCF_RESP_SLVERR}, {30'h0, r});
    POR_RESET_N <= 1'b0;
    @(posedge CLK);
    POR_RESET_N <= 1'b1;
    bus(1'b0, rcf_pkg::RCF_ADDR_STATUS, 32'h0);
    chk("flags", 32'h0, v);
    results;
  end
  initial begin
    repeat (3000) @(posedge CLK);
    miscompares++;
    results;
  end
endmodule
